// File: design/tap_scan_pkg.sv
// Contract
// - Shift-IR moves instruction bits toward the output
// - Shift-IR: mode high exits, low stays
// - Scan states never disturb instruction or data
// - Exit1-IR: high to update, low to pause
// - Pause-IR holds shifting; high goes to Exit2
// - Exit2-IR: high to update, low to shift
// - Update-IR latches instruction on falling edge
// - Latched instruction becomes the active one
// - Update-IR leaves data registers unchanged
// - Capture-IR loads 100, then exit or shift
// - Select-IR: low to capture, high to reset
// - Five high mode edges reset, load identify
package tap_scan_pkg;

  localparam int IR_WIDTH = 3;
  localparam logic [2:0] IR_CAPTURE_PATTERN = 3'h4;
  localparam logic [2:0] IR_IDENTIFY = 3'h1;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam int RESET_TMS_EDGES = 5;
  localparam int TCK_HALF_DIV = 5;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EXIT1_DR = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EXIT2_DR = 4'h4,
    ST_UPD_DR = 4'hC,
    ST_SEL_IR = 4'hD,
    ST_CAP_IR = 4'hF,
    ST_SHIFT_IR = 4'hE,
    ST_EXIT1_IR = 4'hA,
    ST_PAUSE_IR = 4'hB,
    ST_EXIT2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } tap_state_t;

  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    case (s)
      ST_RESET: tap_next = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
      default: tap_next = ST_RESET;
    endcase
  endfunction

endpackage

// File: design/tap_link_if.sv
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;

  modport device_end (input tck, input tms, input tdi, output tdo, output tdo_oe);
  modport tester_end (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

// File: design/tap_device.sv
module tap_device
  import tap_scan_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Link to the tester.
  tap_link_if.device_end link,
  // Local view.
  output logic [IR_WIDTH-1:0] active_instr,
  output tap_state_t tap_state,
  output logic dr_hold
);

  logic [2:0] tck_sync_ff;
  logic [1:0] tms_sync_ff;
  logic [1:0] tdi_sync_ff;
  tap_state_t state_ff;
  logic [IR_WIDTH-1:0] ir_shift_ff;
  logic [IR_WIDTH-1:0] ir_active_ff;
  logic bypass_ff;
  logic tdo_ff;
  logic tdo_oe_ff;

  // The third tck stage only feeds edge detection, never the first stage.
  wire tck_rise = tck_sync_ff[1] & ~tck_sync_ff[2];
  wire tck_fall = ~tck_sync_ff[1] & tck_sync_ff[2];
  wire tms_s = tms_sync_ff[1];
  wire tdi_s = tdi_sync_ff[1];
  wire in_shift_ir = (state_ff == ST_SHIFT_IR);
  wire in_shift_dr = (state_ff == ST_SHIFT_DR);
  wire [IR_WIDTH-1:0] nxt_ir_shift = {tdi_s, ir_shift_ff[IR_WIDTH-1:1]};

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tck_sync_ff <= 3'h0;
      tms_sync_ff <= 2'h3;
      tdi_sync_ff <= 2'h0;
    end else begin
      tck_sync_ff <= {tck_sync_ff[1:0], link.tck};
      tms_sync_ff <= {tms_sync_ff[0], link.tms};
      tdi_sync_ff <= {tdi_sync_ff[0], link.tdi};
    end
  end

  // The full state graph also yields the five-high return to reset.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_ff <= ST_RESET;
    end else if (tck_rise) begin
      state_ff <= tap_next(state_ff, tms_s);
    end
  end

  // Instruction shift path; untouched outside capture and shift.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ir_shift_ff <= IR_CAPTURE_PATTERN;
    end else if (tck_rise && state_ff == ST_CAP_IR) begin
      ir_shift_ff <= IR_CAPTURE_PATTERN;
    end else if (tck_rise && in_shift_ir) begin
      ir_shift_ff <= nxt_ir_shift;
    end
  end

  // Active instruction changes on the falling edge in Update-IR, and returns to identify while in Test-Logic-Reset.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ir_active_ff <= IR_IDENTIFY;
    end else if (state_ff == ST_RESET) begin
      ir_active_ff <= IR_IDENTIFY;
    end else if (tck_fall && state_ff == ST_UPD_IR) begin
      ir_active_ff <= ir_shift_ff;
    end
  end

  // Stand-in one-bit data register; it moves only in Shift-DR.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bypass_ff <= 1'h0;
    end else if (tck_rise && in_shift_dr) begin
      bypass_ff <= tdi_s;
    end
  end

  // Output changes on the falling edge so the tester samples it stable.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tdo_ff <= 1'h0;
      tdo_oe_ff <= 1'h0;
    end else if (tck_fall) begin
      tdo_oe_ff <= in_shift_ir | in_shift_dr;
      tdo_ff <= in_shift_ir ? ir_shift_ff[0] : bypass_ff;
    end
  end

  assign link.tdo = tdo_ff;
  assign link.tdo_oe = tdo_oe_ff;
  assign active_instr = ir_active_ff;
  assign tap_state = state_ff;
  assign dr_hold = (state_ff != ST_SHIFT_DR) && (state_ff != ST_CAP_DR);

endmodule

// File: design/tap_tester.sv
module tap_tester
  import tap_scan_pkg::*;
#(
  parameter int HALF_DIV = TCK_HALF_DIV
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Link to the device.
  tap_link_if.tester_end link,
  // Command side: one tck cycle per accepted step.
  input wire logic step_valid,
  output logic step_ready,
  input wire logic step_tms,
  input wire logic step_tdi,
  output logic tdo_valid,
  output logic tdo_bit,
  output tap_state_t tap_state
);

  // The device needs a few clocks per link level, and the divider counts in eight bits.
  if (HALF_DIV < 4 || HALF_DIV > 256) begin : g_bad_half_div
    $error("HALF_DIV out of range");
  end

  logic [7:0] div_ff;
  logic tck_ff;
  logic busy_ff;
  logic tms_ff;
  logic tdi_ff;
  logic [1:0] tdo_sync_ff;
  logic tdo_valid_ff;
  logic tdo_bit_ff;
  tap_state_t state_ff;

  wire half_tick = (div_ff == 8'(HALF_DIV - 1));
  wire take = step_valid && step_ready;
  wire rise_now = busy_ff && half_tick && !tck_ff;
  wire fall_now = busy_ff && half_tick && tck_ff;

  assign step_ready = !busy_ff;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_ff <= 8'h00;
      tck_ff <= 1'h0;
      busy_ff <= 1'h0;
      tms_ff <= 1'h1;
      tdi_ff <= 1'h0;
    end else begin
      div_ff <= (!busy_ff || half_tick) ? 8'h00 : div_ff + 8'h01;
      if (take) begin
        busy_ff <= 1'h1;
        tms_ff <= step_tms;
        tdi_ff <= step_tdi;
      end else if (rise_now) begin
        tck_ff <= 1'h1;
      end else if (fall_now) begin
        tck_ff <= 1'h0;
        busy_ff <= 1'h0;
      end
    end
  end

  // Mirror of the device state, advanced at each rising edge made here.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_ff <= ST_RESET;
    end else if (rise_now) begin
      state_ff <= tap_next(state_ff, tms_ff);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tdo_sync_ff <= 2'h0;
      tdo_valid_ff <= 1'h0;
      tdo_bit_ff <= 1'h0;
    end else begin
      tdo_sync_ff <= {tdo_sync_ff[0], link.tdo};
      tdo_valid_ff <= rise_now;
      if (rise_now) begin
        tdo_bit_ff <= tdo_sync_ff[1];
      end
    end
  end

  assign link.tck = tck_ff;
  assign link.tms = tms_ff;
  assign link.tdi = tdi_ff;
  assign tdo_valid = tdo_valid_ff;
  assign tdo_bit = tdo_bit_ff;
  assign tap_state = state_ff;

endmodule

// File: test/tap_instruction_scan_path_monitor.sv
module tap_instruction_scan_path_monitor
  import tap_scan_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Link and device view.
  input wire logic tms,
  input wire logic tdo_oe,
  input wire tap_state_t tap_state,
  input wire logic [IR_WIDTH-1:0] active_instr,
  input wire logic dr_hold
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Link edges reach the device late, so a branch is judged when the state moves; tms is held that long.
  sequence left(tap_state_t s);
    $past(tap_state) == s && tap_state != s;
  endsequence
  property branch(tap_state_t s, tap_state_t hi, tap_state_t lo);
    left(s) |-> tap_state == (tms ? hi : lo);
  endproperty
  chk_shift_exit: assert property (branch(ST_SHIFT_IR, ST_EXIT1_IR, ST_SHIFT_IR)) else $error("bad branch");
  chk_exit1_branch: assert property (branch(ST_EXIT1_IR, ST_UPD_IR, ST_PAUSE_IR)) else $error("bad branch");
  chk_exit2_branch: assert property (branch(ST_EXIT2_IR, ST_UPD_IR, ST_SHIFT_IR)) else $error("bad branch");
  chk_capture_branch: assert property (branch(ST_CAP_IR, ST_EXIT1_IR, ST_SHIFT_IR)) else $error("bad branch");
  chk_select_branch: assert property (branch(ST_SEL_IR, ST_RESET, ST_CAP_IR)) else $error("bad branch");
  chk_update_branch: assert property (branch(ST_UPD_IR, ST_SEL_DR, ST_IDLE)) else $error("bad branch");
  chk_instr_frozen: assert property (
    tap_state inside {ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR} |-> $stable(active_instr))
    else $error("instruction moved in scan");
  chk_instr_latch: assert property (
    $changed(active_instr) |-> tap_state inside {ST_UPD_IR, ST_RESET}) else $error("instruction moved");
  chk_oe_shift: assert property ($rose(tdo_oe) |-> tap_state inside {ST_SHIFT_IR, ST_SHIFT_DR}) else $error("bad oe");
  chk_dr_frozen: assert property (tap_state == ST_UPD_IR |-> dr_hold) else $error("data moved");
  chk_reset_ident: assert property (
    (tap_state == ST_RESET) [*2] |-> active_instr == IR_IDENTIFY) else $error("no identify");
endmodule

// File: test/test_tap_instruction_scan_path.sv
module test_tap_instruction_scan_path import tap_scan_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] INSTR_A = 3'h3;
  localparam logic [2:0] INSTR_B = 3'h6;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic step_valid = 1'b0;
  logic step_tms = 1'b1;
  logic step_tdi = 1'b0;
  logic step_ready;
  logic tdo_valid;
  logic tdo_bit;
  logic dr_hold;
  logic [IR_WIDTH-1:0] active_instr;
  tap_state_t dev_state;
  tap_state_t tst_state;
  int error_cnt = 0;
  int n_checks = 0;
  tap_link_if link();
  tap_device i_tap_device(.clock(clock), .reset_n(reset_n), .link(link.device_end), .active_instr(active_instr),
    .tap_state(dev_state), .dr_hold(dr_hold));
  tap_tester i_tap_tester(.clock(clock), .reset_n(reset_n), .link(link.tester_end), .step_valid(step_valid),
    .step_ready(step_ready), .step_tms(step_tms), .step_tdi(step_tdi), .tdo_valid(tdo_valid),
    .tdo_bit(tdo_bit), .tap_state(tst_state));
  tap_instruction_scan_path_monitor i_tap_instruction_scan_path_monitor(.clock(clock), .reset_n(reset_n),
    .tms(link.tms), .tdo_oe(link.tdo_oe), .tap_state(dev_state), .active_instr(active_instr), .dr_hold(dr_hold));
  initial forever #4 clock = ~clock;
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // Waiting for ready before the state check gives the device time to see the same link edge.
  task automatic step(input logic m, input logic d, input tap_state_t exp, output logic q);
    int n;
    step_tms = m;
    step_tdi = d;
    step_valid = 1'b1;
    @(negedge clock);
    step_valid = 1'b0;
    for (n = 0; n < 40 && tdo_valid !== 1'b1; n++) @(negedge clock);
    chk(tdo_valid === 1'b1, "no sample pulse");
    q = tdo_bit;
    for (n = n; n < 80 && step_ready !== 1'b1; n++) @(negedge clock);
    chk(tst_state === exp, "tester mirror state");
    for (n = n; n < 120 && dev_state !== exp; n++) @(negedge clock);
    chk(n < 120, "wrong state or timeout");
    if (n >= 120) test_done();
  endtask
  task automatic go(input logic m, input tap_state_t exp);
    logic q;
    step(m, 1'b0, exp, q);
  endtask
  task automatic to_capture();
    go(1'b1, ST_SEL_DR);
    go(1'b1, ST_SEL_IR);
    go(1'b0, ST_CAP_IR);
  endtask
  task automatic shift_ir(input logic [2:0] din, input logic [2:0] dout);
    logic q;
    for (int i = 0; i < IR_WIDTH; i++) begin
      step(i == IR_WIDTH - 1, din[i], (i == IR_WIDTH - 1) ? ST_EXIT1_IR : ST_SHIFT_IR, q);
      chk(q === dout[i], "serial bit");
      chk(active_instr === IR_IDENTIFY, "instruction moved");
    end
  endtask
  task automatic t_scan();
    go(1'b0, ST_IDLE);
    to_capture();
    go(1'b0, ST_SHIFT_IR);
    shift_ir(INSTR_A, IR_CAPTURE_PATTERN);
  endtask
  task automatic t_pause();
    go(1'b0, ST_PAUSE_IR);
    go(1'b0, ST_PAUSE_IR);
    go(1'b1, ST_EXIT2_IR);
    go(1'b0, ST_SHIFT_IR);
    shift_ir(INSTR_B, INSTR_A);
  endtask
  task automatic t_update();
    go(1'b1, ST_UPD_IR);
    go(1'b0, ST_IDLE);
    chk(active_instr === INSTR_B, "not latched");
  endtask
  task automatic t_reset();
    to_capture();
    go(1'b1, ST_EXIT1_IR);
    go(1'b0, ST_PAUSE_IR);
    go(1'b1, ST_EXIT2_IR);
    go(1'b1, ST_UPD_IR);
    go(1'b1, ST_SEL_DR);
    chk(active_instr === IR_CAPTURE_PATTERN, "not latched");
    go(1'b1, ST_SEL_IR);
    go(1'b1, ST_RESET);
    chk(active_instr === IR_IDENTIFY, "no identify");
  endtask
  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    t_scan();
    t_pause();
    t_update();
    t_reset();
    test_done();
  end
endmodule
